// ==== inc/spc_consts.svh ====
/*
 * Constants of the serial programming checker: address windows, record
 * fields, message bytes and limits.
 * Assumes a 16-bit flash address space with the flash at the top.
 */
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
`define SPC_FLASH_LO   16'hC000
`define SPC_FLASH_HI   16'hFFFF
`define SPC_PW_HI      16'hFF9F
`define SPC_PW_LIM     16'hFFA0
`define SPC_BLANK_LO   16'hFFE0
`define SPC_BLANK_SUM  16'h1FE0
`define SPC_EXT_LIM    16'h1000
`define SPC_START      8'h3A
`define SPC_RT_DATA    8'h00
`define SPC_RT_END     8'h01
`define SPC_RT_EXT     8'h02
`define SPC_EXT_LEN    8'h02
`define SPC_END_LEN    8'h00
`define SPC_PW_MIN     8'h08
`define SPC_RUN_MAX    2'h3
`define SPC_ADDR_LAST  4'h3
`define SPC_HDR_LAST   4'h3
`define SPC_ID_CNT     8'h0A
`define SPC_ADDR_LEN   8'h02
`define SPC_ROM_BLK    8'h01
`define SPC_STAT_CNT   8'h04
`define SPC_PROT_OK    8'hFB
`define SPC_LEN_SUM    8'h02
`define SPC_LEN_ID     8'h0D
`define SPC_LEN_STAT   8'h07
`define SPC_LEN_PROT   8'h01
`define SPC_CKS_FIRST  8'h02
`endif

// ==== inc/spc_pkg.sv ====
/*
 * Types of the serial programming checker: modes, states, jobs, message
 * kinds, the write carrier and the state records.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package spc_pkg;
   typedef enum logic [2:0] {
      MD_WRITE = 3'h0, MD_RAM = 3'h1, MD_SUM = 3'h2, MD_ERASE = 3'h3,
      MD_ID = 3'h4, MD_STAT = 3'h5, MD_PROT = 3'h6
   } spc_mode_t;
   typedef enum logic [3:0] {
      S_IDLE = 4'h0, S_ADDR = 4'h1, S_SUM = 4'h2, S_PW = 4'h3, S_PWW = 4'h4,
      S_PWC = 4'h5, S_RWAIT = 4'h6, S_RHDR = 4'h7, S_RDAT = 4'h8,
      S_RCKS = 4'h9, S_TX = 4'hA, S_HALT = 4'hB
   } spc_state_t;
   typedef enum logic [1:0] {J_BLANK = 2'h0, J_CNT = 2'h1, J_FINAL = 2'h2} spc_job_t;
   typedef enum logic [1:0] {TK_SUM = 2'h0, TK_ID = 2'h1, TK_STAT = 2'h2, TK_PROT = 2'h3} spc_tk_t;
   typedef struct packed {
      logic        valid;
      logic        ram;
      logic [15:0] addr;
      logic [7:0]  data;
   } spc_wr_t;
   typedef struct packed {
      spc_state_t  st;
      spc_mode_t   mode;
      spc_job_t    job;
      spc_tk_t     tk;
      logic [15:0] password_count_addr;
      logic [15:0] password_compare_start;
      logic [15:0] ptr;
      logic [15:0] end_a;
      logic        rd;
      logic        pend;
      logic        ram;
      logic [3:0]  cnt;
      logic [7:0]  len;
      logic [15:0] raddr;
      logic [7:0]  rtype;
      logic [7:0]  rcks;
      logic [7:0]  idx;
      logic [7:0]  pwlen;
      logic [7:0]  prev;
      logic [1:0]  run;
      logic [7:0]  pwbyte;
      logic        ext_ge;
      logic [15:0] ext;
      logic [15:0] first;
      logic [15:0] last;
      logic        got;
      logic        blank;
      logic        txv;
      logic [7:0]  txd;
      spc_wr_t     wr;
   } spc_st_t;
   typedef struct packed {
      logic [15:0] sum;
   } spc_acc_t;
endpackage

// ==== rtl/spc_sum_acc.sv ====
/*
 * Byte-sum accumulator returning a 16-bit word.
 * Assumes clear and add are never raised together by the caller.
 */
`timescale 1ns/100ps
module spc_sum_acc
   import spc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_clr,
   input  wire logic        i_add,
   input  wire logic [7:0]  i_byte,
   output logic      [15:0] o_sum
);
   spc_acc_t q, d;

   always_comb begin
      d = q;
      if (i_clr) begin
         d.sum = 16'h0000;
      end else if (i_add) begin
         // carry out of the top byte is simply lost
         d.sum = q.sum + {8'h00, i_byte};
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_sum = q.sum;
endmodule // spc_sum_acc

// ==== rtl/spc_prog_check.sv ====
/*
 * Serial programming checker: checksums, hex record parsing, password
 * checks, identification and status messages, halt on any error.
 * Assumes a framed byte receiver, a byte transmitter with ready, and a
 * memory read port answering one cycle after the read strobe.
 */
// How it works
// - checksum adds bytes, returns 16-bit word
// - write and sum modes cover whole flash
// - RAM loader sums first to last RAM address
// - message checksums cover payload bytes only
// - erase sums erased sectors or whole flash
// - after record, ignore all until start mark
// - receive or format error halts silently
// - unknown record type or bad checksum fails
// - extended record length must be two
// - data after high extended address fails
// - end record length must be zero
// - password lies in window below boundary
// - all-ones top region means blank, skip compare
// - count address, count, start address checked
// - three identical consecutive password bytes fail
// - password constraint violation halts silently
// - blank device expects records right after addresses
// - password mismatch halts until device reset
// - identification message is thirteen fixed bytes
// - last identification byte negates payload sum
`timescale 1ns/100ps
`include "spc_consts.svh"
module spc_prog_check
   import spc_pkg::*;
#(
   parameter logic [7:0] P_ID_RSVD = 8'h5A // arbitrary identity byte
)(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_cmd_valid,
   input  wire spc_mode_t   i_cmd_mode,
   output logic             o_cmd_ready,
   input  wire logic        i_rx_valid,
   input  wire logic [7:0]  i_rx_data,
   input  wire logic        i_rx_err,
   input  wire logic [15:0] i_erase_start,
   input  wire logic [15:0] i_erase_end,
   input  wire logic        i_rd_prot,
   output logic             o_mem_rd,
   output logic      [15:0] o_mem_addr,
   output logic             o_mem_ram,
   input  wire logic [7:0]  i_mem_data,
   output spc_wr_t          o_wr,
   output logic             o_tx_valid,
   output logic      [7:0]  o_tx_data,
   input  wire logic        i_tx_ready,
   output logic             o_blank,
   output logic             o_halt,
   output logic             o_busy
);
   spc_st_t     q, d;
   logic        acc_clr;
   logic        acc_add;
   logic [7:0]  acc_byte;
   logic [15:0] acc_sum;
   logic [15:0] er_lo;
   logic [15:0] er_hi;
   logic [7:0]  tx_len;

   spc_sum_acc u_acc (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_clr   (acc_clr),
      .i_add   (acc_add),
      .i_byte  (acc_byte),
      .o_sum   (acc_sum)
   );

   function automatic spc_st_t go_sum(spc_st_t s, logic [15:0] lo, logic [15:0] hi, logic ram,
                                      spc_job_t j);
      spc_st_t r;
      r       = s;
      r.st    = S_SUM;
      r.ptr   = lo;
      r.end_a = hi;
      r.ram   = ram;
      r.job   = j;
      r.rd    = 1'b1;
      r.pend  = 1'b0;
      return r;
   endfunction

   function automatic logic [7:0] msg(spc_tk_t k, logic [7:0] i, logic [15:0] s, logic bl, logic rp);
      logic [7:0] m;
      m = 8'h00;
      case (k)
         TK_SUM:  m = (i == 8'h00) ? s[15:8] : s[7:0];
         TK_PROT: m = `SPC_PROT_OK;
         TK_STAT: begin
            case (i)
               8'h00:   m = `SPC_START;
               8'h01:   m = `SPC_STAT_CNT;
               8'h02:   m = {6'h00, rp, ~bl};
               8'h06:   m = 8'h00 - s[7:0];
               default: m = 8'h00;
            endcase
         end
         default: begin
            case (i)
               8'h00:   m = `SPC_START;
               8'h01:   m = `SPC_ID_CNT;
               8'h02:   m = `SPC_ADDR_LEN;
               8'h03:   m = P_ID_RSVD;
               8'h07:   m = `SPC_ROM_BLK;
               8'h08:   m = 8'(`SPC_FLASH_LO >> 8);
               8'h09:   m = 8'(`SPC_FLASH_LO & 16'h00FF);
               8'h0A:   m = 8'(`SPC_FLASH_HI >> 8);
               8'h0B:   m = 8'(`SPC_FLASH_HI & 16'h00FF);
               8'h0C:   m = 8'h00 - s[7:0];
               default: m = 8'h00;
            endcase
         end
      endcase
      return m;
   endfunction

   // chip erase when start lies above end
   assign er_lo  = (i_erase_start <= i_erase_end) ? i_erase_start : `SPC_FLASH_LO;
   assign er_hi  = (i_erase_start <= i_erase_end) ? i_erase_end : `SPC_FLASH_HI;
   assign tx_len = (q.tk == TK_SUM) ? `SPC_LEN_SUM : (q.tk == TK_ID) ? `SPC_LEN_ID :
                   (q.tk == TK_STAT) ? `SPC_LEN_STAT : `SPC_LEN_PROT;

   always_comb begin
      logic [1:0] nrun;
      logic       bad;
      nrun     = 2'h1;
      bad      = 1'b0;
      d        = q;
      acc_clr  = 1'b0;
      acc_add  = 1'b0;
      acc_byte = i_mem_data;
      d.wr.valid = 1'b0;
      if (q.st != S_IDLE && q.st != S_HALT && i_rx_err) begin
         d.st  = S_HALT;
         // a byte left standing on tx would still be taken by the sink
         d.txv = 1'b0;
         d.rd  = 1'b0;
      end else begin
         case (q.st)
            S_IDLE: begin
               if (i_cmd_valid) begin
                  d.mode   = i_cmd_mode;
                  d.cnt    = 4'h0;
                  d.got    = 1'b0;
                  d.ext_ge = 1'b0;
                  d.idx    = 8'h00;
                  acc_clr  = 1'b1;
                  case (i_cmd_mode)
                     MD_SUM:  d = go_sum(d, `SPC_FLASH_LO, `SPC_FLASH_HI, 1'b0, J_FINAL);
                     MD_STAT: d = go_sum(d, `SPC_BLANK_LO, `SPC_FLASH_HI, 1'b0, J_BLANK);
                     MD_ID: begin
                        d.tk = TK_ID;
                        d.st = S_TX;
                     end
                     default: d.st = S_ADDR;
                  endcase
               end
            end
            S_ADDR: begin
               if (i_rx_valid) begin
                  d.password_count_addr = {q.password_count_addr[7:0], q.password_compare_start[15:8]};
                  d.password_compare_start = {q.password_compare_start[7:0], i_rx_data};
                  d.cnt  = q.cnt + 4'h1;
                  if (q.cnt == `SPC_ADDR_LAST) begin
                     if (d.password_count_addr < `SPC_FLASH_LO || d.password_count_addr > `SPC_PW_HI ||
                         d.password_compare_start < `SPC_FLASH_LO || d.password_compare_start > `SPC_PW_HI) begin
                        d.st = S_HALT;
                     end else begin
                        d = go_sum(d, `SPC_BLANK_LO, `SPC_FLASH_HI, 1'b0, J_BLANK);
                        acc_clr = 1'b1;
                     end
                  end
               end
            end
            S_SUM: begin
               if (q.rd) begin
                  if (q.ptr == q.end_a) begin
                     d.rd = 1'b0;
                  end else begin
                     d.ptr = q.ptr + 16'h0001;
                  end
               end
               d.pend  = q.rd;
               acc_add = q.pend;
               if (!q.rd && !q.pend) begin
                  case (q.job)
                     J_BLANK: begin
                        // all-ones is the only way 32 bytes reach this sum
                        d.blank = (acc_sum == `SPC_BLANK_SUM);
                        if (q.mode == MD_STAT) begin
                           d.tk    = TK_STAT;
                           d.st    = S_TX;
                           d.idx   = 8'h00;
                           acc_clr = 1'b1;
                        end else if (d.blank) begin
                           acc_clr = 1'b1;
                           case (q.mode)
                              MD_ERASE: d = go_sum(d, er_lo, er_hi, 1'b0, J_FINAL);
                              MD_PROT:  d.st = S_HALT;
                              default:  d.st = S_RWAIT;
                           endcase
                        end else begin
                           d = go_sum(d, q.password_count_addr, q.password_count_addr, 1'b0, J_CNT);
                           acc_clr = 1'b1;
                        end
                     end
                     J_CNT: begin
                        d.pwlen = acc_sum[7:0];
                        if (acc_sum[7:0] < `SPC_PW_MIN ||
                            q.password_compare_start > `SPC_PW_LIM - {8'h00, acc_sum[7:0]}) begin
                           d.st = S_HALT;
                        end else begin
                           d.st  = S_PW;
                           d.idx = 8'h00;
                        end
                     end
                     default: begin
                        d.tk  = TK_SUM;
                        d.st  = S_TX;
                        d.idx = 8'h00;
                     end
                  endcase
               end
            end
            S_PW: begin
               if (i_rx_valid) begin
                  if (q.idx != 8'h00 && i_rx_data == q.prev) begin
                     nrun = q.run + 2'h1;
                  end
                  d.run    = nrun;
                  d.prev   = i_rx_data;
                  d.pwbyte = i_rx_data;
                  if (nrun == `SPC_RUN_MAX) begin
                     d.st = S_HALT;
                  end else begin
                     d.ptr = q.password_compare_start + {8'h00, q.idx};
                     d.ram = 1'b0;
                     d.rd  = 1'b1;
                     d.st  = S_PWW;
                  end
               end
            end
            S_PWW: begin
               d.rd = 1'b0;
               d.st = S_PWC;
            end
            S_PWC: begin
               if (i_mem_data != q.pwbyte) begin
                  d.st = S_HALT;
               end else begin
                  d.idx = q.idx + 8'h01;
                  d.st  = S_PW;
                  if (d.idx == q.pwlen) begin
                     acc_clr = 1'b1;
                     case (q.mode)
                        MD_ERASE: d = go_sum(d, er_lo, er_hi, 1'b0, J_FINAL);
                        MD_PROT: begin
                           d.tk  = TK_PROT;
                           d.st  = S_TX;
                           d.idx = 8'h00;
                        end
                        default: d.st = S_RWAIT;
                     endcase
                  end
               end
            end
            S_RWAIT: begin
               if (i_rx_valid && i_rx_data == `SPC_START) begin
                  d.st   = S_RHDR;
                  d.cnt  = 4'h0;
                  d.rcks = 8'h00;
               end
            end
            S_RHDR: begin
               if (i_rx_valid) begin
                  d.rcks = q.rcks + i_rx_data;
                  d.cnt  = q.cnt + 4'h1;
                  case (q.cnt)
                     4'h0:    d.len = i_rx_data;
                     4'h1:    d.raddr[15:8] = i_rx_data;
                     4'h2:    d.raddr[7:0] = i_rx_data;
                     default: d.rtype = i_rx_data;
                  endcase
                  if (q.cnt == `SPC_HDR_LAST) begin
                     bad = (i_rx_data > `SPC_RT_EXT) ||
                           (i_rx_data == `SPC_RT_EXT && q.len != `SPC_EXT_LEN) ||
                           (i_rx_data == `SPC_RT_END && q.len != `SPC_END_LEN) ||
                           (i_rx_data == `SPC_RT_DATA && q.ext_ge);
                     d.idx = 8'h00;
                     d.st  = bad ? S_HALT : (q.len == 8'h00) ? S_RCKS : S_RDAT;
                  end
               end
            end
            S_RDAT: begin
               if (i_rx_valid) begin
                  d.rcks = q.rcks + i_rx_data;
                  d.idx  = q.idx + 8'h01;
                  if (q.rtype == `SPC_RT_DATA) begin
                     d.wr.valid = 1'b1;
                     d.wr.ram   = (q.mode == MD_RAM);
                     d.wr.addr  = q.raddr + {8'h00, q.idx};
                     d.wr.data  = i_rx_data;
                     if (q.mode == MD_RAM) begin
                        d.first = q.got ? q.first : d.wr.addr;
                        d.last  = d.wr.addr;
                        d.got   = 1'b1;
                     end
                  end else begin
                     d.ext = {q.ext[7:0], i_rx_data};
                  end
                  if (d.idx == q.len) begin
                     d.st = S_RCKS;
                  end
               end
            end
            S_RCKS: begin
               if (i_rx_valid) begin
                  d.st = S_RWAIT;
                  if (q.rcks + i_rx_data != 8'h00) begin
                     d.st = S_HALT;
                  end else if (q.rtype == `SPC_RT_EXT) begin
                     d.ext_ge = (q.ext >= `SPC_EXT_LIM);
                  end else if (q.rtype == `SPC_RT_END) begin
                     acc_clr = 1'b1;
                     if (q.mode != MD_RAM) begin
                        d = go_sum(d, `SPC_FLASH_LO, `SPC_FLASH_HI, 1'b0, J_FINAL);
                     end else if (q.got) begin
                        d = go_sum(d, q.first, q.last, 1'b1, J_FINAL);
                     end else begin
                        d.tk  = TK_SUM;
                        d.st  = S_TX;
                        d.idx = 8'h00;
                     end
                  end
               end
            end
            S_TX: begin
               acc_byte = q.txd;
               if (!q.txv) begin
                  d.txd = msg(q.tk, q.idx, acc_sum, q.blank, i_rd_prot);
                  d.txv = 1'b1;
               end else if (i_tx_ready) begin
                  d.txv   = 1'b0;
                  d.idx   = q.idx + 8'h01;
                  acc_add = (q.tk != TK_SUM) && (q.idx >= `SPC_CKS_FIRST) &&
                            (q.idx < tx_len - 8'h01);
                  if (d.idx == tx_len) begin
                     d.st = S_IDLE;
                  end
               end
            end
            S_HALT:  d.st = S_HALT;
            default: d.st = S_HALT;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_cmd_ready = (q.st == S_IDLE);
   assign o_mem_rd    = q.rd;
   assign o_mem_addr  = q.ptr;
   assign o_mem_ram   = q.ram;
   assign o_wr        = q.wr;
   assign o_tx_valid  = q.txv;
   assign o_tx_data   = q.txd;
   assign o_blank     = q.blank;
   assign o_halt      = (q.st == S_HALT);
   assign o_busy      = (q.st != S_IDLE) && (q.st != S_HALT);

   AST_HALT_STAYS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_halt |=> o_halt [*8]) else $error("halt left without reset");
   AST_RXERR_HALT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_busy && i_rx_err |=> o_halt && !o_tx_valid) else $error("receive error did not halt");
   AST_BAD_TYPE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      q.st == S_RHDR && i_rx_valid && !i_rx_err && q.cnt == `SPC_HDR_LAST && i_rx_data > `SPC_RT_EXT
      |=> o_halt) else $error("bad record type accepted");
   AST_EXT_LEN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      q.st == S_RHDR && i_rx_valid && !i_rx_err && q.cnt == `SPC_HDR_LAST &&
      i_rx_data == `SPC_RT_EXT && q.len != `SPC_EXT_LEN |=> o_halt) else $error("extended length accepted");
   AST_END_LEN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      q.st == S_RHDR && i_rx_valid && !i_rx_err && q.cnt == `SPC_HDR_LAST &&
      i_rx_data == `SPC_RT_END && q.len != `SPC_END_LEN |=> o_halt) else $error("end length accepted");
   AST_IGNORE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      q.st == S_RWAIT && !i_rx_err && !(i_rx_valid && i_rx_data == `SPC_START)
      |=> q.st == S_RWAIT && !o_wr.valid) else $error("byte outside record not ignored");
   AST_SUM_ADD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      q.st == S_SUM && q.pend && !i_rx_err |=> acc_sum == $past(acc_sum) + {8'h00, $past(i_mem_data)})
      else $error("checksum did not add read byte");
   AST_PW_RUN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      q.st == S_PW && i_rx_valid && !i_rx_err && q.idx != 8'h00 && q.run == 2'h2 && i_rx_data == q.prev
      |=> o_halt) else $error("repeated password bytes accepted");
   AST_PW_MISMATCH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      q.st == S_PWC && !i_rx_err && i_mem_data != q.pwbyte |=> o_halt) else $error("password mismatch accepted");
endmodule // spc_prog_check

// ==== verif/spc_far_model.sv ====
/*
 * far side of the checker: flash and ram image answering reads one cycle
 * late, taking record writes, and a byte sink that stalls now and then.
 * assumes the bench preloads mem by hierarchical access.
 */
`timescale 1ns/100ps
module spc_far_model
   import spc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rd,
   input  wire logic [15:0] i_addr,
   input  wire spc_wr_t     i_wr,
   output logic      [7:0]  o_data,
   output logic             o_ready
);
   logic [7:0] mem [0:65535];
   logic [1:0] cnt;
   initial begin
      o_data = 8'h00;
      cnt = 2'h0;
   end
   always @(posedge i_clk) begin
      cnt <= cnt + 2'h1;
      // idle bus flips so a stale byte never passes for data
      o_data <= i_rd ? mem[i_addr] : ~o_data;
      if (i_wr.valid === 1'b1) begin
         mem[i_wr.addr] <= i_wr.data;
      end
   end
   // sink stalls one cycle in four
   assign o_ready = (cnt != 2'h3);
endmodule // spc_far_model

// ==== verif/testbench.sv ====
/*
 * bench: drives commands and bytes, queues the bytes due on tx.
 * assumes spc_far_model as memory and byte sink.
 */
`timescale 1ns/100ps
module testbench import spc_pkg::*; ;
   localparam logic [7:0] ID_B = 8'h6C; // arbitrary identity byte
   logic        clk, rst_n, cv, rxv, rxe, prot, rd, ram, txv, rdy, blank, halt, busy, crdy;
   spc_mode_t   mode;
   logic [7:0]  rxd, md, txd, s8, p [8], idb [12];
   logic [15:0] ma, s16, dw, es;
   spc_wr_t     wr;
   logic [7:0]  expq [$];
   int          err_count, checks, seed;
   spc_prog_check #(.P_ID_RSVD(ID_B)) u_spc_prog_check (.i_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(cv),
      .i_cmd_mode(mode), .o_cmd_ready(crdy), .i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_err(rxe),
      .i_erase_start(es), .i_erase_end(16'hE0FF), .i_rd_prot(prot), .o_mem_rd(rd), .o_mem_addr(ma),
      .o_mem_ram(ram), .i_mem_data(md), .o_wr(wr), .o_tx_valid(txv), .o_tx_data(txd),
      .i_tx_ready(rdy), .o_blank(blank), .o_halt(halt), .o_busy(busy));
   spc_far_model u_spc_far_model (.i_clk(clk), .i_rd(rd), .i_addr(ma), .i_wr(wr), .o_data(md), .o_ready(rdy));
   always #10 clk = ~clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      if (txv === 1'b1 && rdy === 1'b1) begin
         if (expq.size() == 0)
            chk(8'h00, 8'hFF); // no byte may leave unannounced
         else
            chk(txd, expq.pop_front());
      end
   end
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask
   task automatic cmd(input spc_mode_t m);
      mode <= m;
      cv <= 1'b1;
      @(posedge clk) cv <= 1'b0;
      @(posedge clk);
   endtask
   task automatic tx_byte(input logic [7:0] b);
      rxd <= b;
      rxv <= 1'b1;
      @(posedge clk) rxv <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic addrs(input logic [15:0] c, input logic [15:0] st);
      tx_byte(c[15:8]);
      tx_byte(c[7:0]);
      tx_byte(st[15:8]);
      tx_byte(st[7:0]);
      repeat (40) @(posedge clk); // blank check must finish first
   endtask
   task automatic rec(input logic [7:0] len, input logic [7:0] ty, input logic [15:0] ad,
                      input logic [15:0] d, input logic [7:0] fix);
      logic [7:0] s;
      s = len + ad[15:8] + ad[7:0] + ty;
      tx_byte(8'h3A);
      tx_byte(len);
      tx_byte(ad[15:8]);
      tx_byte(ad[7:0]);
      tx_byte(ty);
      for (int i = 0; i < len; i++) begin
         tx_byte(d[15-8*i -: 8]);
         s += d[15-8*i -: 8];
      end
      tx_byte(-s + fix);
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (crdy !== 1'b1 && halt !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      chk({7'h00, n == 20000 || expq.size() != 0}, 8'h00);
   endtask
   function automatic logic [15:0] sum(input int lo, input int hi);
      logic [15:0] s;
      s = 16'h0000;
      for (int a = lo; a <= hi; a++)
         s += u_spc_far_model.mem[a];
      return s;
   endfunction
   task automatic push16(input logic [15:0] v);
      expq.push_back(v[15:8]);
      expq.push_back(v[7:0]);
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      print_verdict();
   end
   initial begin
      {clk, rst_n, cv, rxv, rxe, prot} = '0;
      mode = MD_WRITE;
      rxd = 8'h00;
      es = 16'hE000;
      seed = 7927;
      err_count = 0;
      checks = 0;
      for (int a = 0; a < 65536; a++)
         u_spc_far_model.mem[a] = (a >= 16'hFFE0) ? 8'hFF : 8'($random(seed));
      do_reset();
      idb = '{8'h3A, 8'h0A, 8'h02, ID_B, 8'h00, 8'h00, 8'h00, 8'h01, 8'hC0, 8'h00, 8'hFF, 8'hFF};
      s8 = 8'h00;
      foreach (idb[i]) begin
         expq.push_back(idb[i]);
         s8 += (i > 1) ? idb[i] : 8'h00;
      end
      expq.push_back(-s8);
      cmd(MD_ID);
      wait_done();
      push16(sum(16'hC000, 16'hFFFF));
      cmd(MD_SUM);
      wait_done();
      dw = 16'($random(seed));
      s16 = sum(16'hC000, 16'hFFFF) - u_spc_far_model.mem[16'hD010] - u_spc_far_model.mem[16'hD011];
      push16(s16 + dw[15:8] + dw[7:0]);
      cmd(MD_WRITE);
      addrs(16'hF000, 16'hF001);
      tx_byte(8'h55);
      rec(8'h02, 8'h00, 16'hD010, dw, 8'h00);
      tx_byte(8'h77);
      rec(8'h00, 8'h01, 16'h0000, 16'h0000, 8'h00);
      wait_done();
      push16({8'h00, dw[15:8]} + dw[7:0]);
      cmd(MD_RAM);
      addrs(16'hF000, 16'hF001);
      rec(8'h02, 8'h00, 16'h0100, dw, 8'h00);
      rec(8'h00, 8'h01, 16'h0000, 16'h0000, 8'h00);
      wait_done();
      prot <= 1'($random(seed));
      @(posedge clk);
      s8 = {6'h00, prot, 1'b0};
      expq = {8'h3A, 8'h04, s8, 8'h00, 8'h00, 8'h00, -s8};
      cmd(MD_STAT);
      wait_done();
      chk({7'h00, blank}, 8'h01);
      for (int e = 0; e < 2; e++) begin
         // start above end asks for the whole flash
         es <= e ? 16'hF000 : 16'hE000;
         @(posedge clk);
         push16(e ? sum(16'hC000, 16'hFFFF) : sum(16'hE000, 16'hE0FF));
         cmd(MD_ERASE);
         addrs(16'hC000, 16'hFF9F);
         wait_done();
      end
      for (int k = 0; k < 7; k++) begin
         do_reset();
         cmd(MD_WRITE);
         addrs(k == 6 ? 16'hFFA0 : 16'hC000, 16'hC000);
         case (k)
            0: rec(8'h00, 8'h03, 16'h0000, 16'h0000, 8'h00);
            1: rec(8'h01, 8'h02, 16'h0000, 16'h0100, 8'h00);
            2: rec(8'h01, 8'h01, 16'h0000, 16'h0100, 8'h00);
            3: rec(8'h02, 8'h00, 16'hC000, dw, 8'h01);
            4: tx_byte(8'h3A);
            5: rec(8'h02, 8'h02, 16'h0000, 16'h1000, 8'h00);
            default: ;
         endcase
         rxe <= (k == 4);
         @(posedge clk) rxe <= 1'b0;
         if (k == 5)
            rec(8'h01, 8'h00, 16'h0000, dw, 8'h00);
         wait_done();
         chk({7'h00, halt}, 8'h01);
      end
      u_spc_far_model.mem[16'hFFFF] = 8'h00;
      u_spc_far_model.mem[16'hF000] = 8'h08;
      for (int k = 0; k < 3; k++) begin
         do_reset();
         for (int i = 0; i < 8; i++) begin
            p[i] = (k == 2 && i < 3) ? 8'hAA : {3'(i), 5'($random(seed))};
            u_spc_far_model.mem[16'hF001 + i] = p[i];
         end
         if (k == 0)
            expq.push_back(8'hFB);
         cmd(MD_PROT);
         addrs(16'hF000, 16'hF001);
         for (int i = 0; i < 8; i++)
            tx_byte(p[i] ^ {7'h00, k == 1 && i == 7});
         wait_done();
         chk({6'h00, blank, halt}, {7'h00, k != 0});
      end
      print_verdict();
   end
endmodule // testbench
